// ==== inc/rtc_pkg.sv ====
// constants and types for the real-time clock register block
package rtc_pkg;
    // bus target address, 11010000b without its direction bit
    localparam logic [6:0] DEV_ADDR = 7'h68;
    localparam logic [7:0] ADDR_SECONDS = 8'h00;
    localparam logic [7:0] ADDR_MINUTES = 8'h01;
    localparam logic [7:0] ADDR_HOURS_CENTURY = 8'h02;
    localparam logic [7:0] ADDR_YEARS = 8'h06;
    localparam logic [7:0] ADDR_CHARGER_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_CONFIG_SECOND = 8'h09;
    localparam logic [7:0] ADDR_SPECIAL_KEY_FIRST = 8'h20;
    localparam logic [7:0] ADDR_SPECIAL_FUNCTION = 8'h22;
    // storage index: 0..9 normal registers, 10..12 special group
    localparam logic [3:0] IDX_SECONDS = 4'h0;
    localparam logic [3:0] IDX_MINUTES = 4'h1;
    localparam logic [3:0] IDX_FIRST_PLAIN = 4'h2;
    localparam logic [3:0] IDX_SPECIAL_BASE = 4'ha;
    localparam logic [3:0] IDX_LAST = 4'hc;
    localparam int IDX_PLAIN_LO = 2;
    localparam int IDX_PLAIN_HI = 12;
    // seconds and minutes field layout
    localparam int STOP_BIT = 7;
    localparam int FAIL_BIT = 7;
    localparam logic [3:0] UNITS_MAX = 4'h9;
    localparam logic [3:0] UNITS_TOP = 4'hf;
    localparam logic [2:0] TENS_MAX = 3'h5;
    localparam logic [2:0] TENS_TOP = 3'h7;
    // reset values
    localparam logic [7:0] RESET_SECONDS = 8'h00;
    localparam logic [7:0] RESET_MINUTES = 8'h80;
    localparam logic [7:0] RESET_PLAIN = 8'h00;
    // serial byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int SECOND_TIME_S = 1;
    localparam int SECOND_CYCLES = SECOND_TIME_S * CLK_HZ;
    localparam int PRE_WIDTH = 25;
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADDR = 8'h02,
        S_ACK = 8'h04,
        S_PTR = 8'h08,
        S_WRITE = 8'h10,
        S_READ = 8'h20,
        S_MACK = 8'h40,
        S_WAIT = 8'h80
    } state_type;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } bus_event_type;
endpackage

// ==== logic/rtc_core.sv ====
// real-time clock register file, seconds counter and two-wire bus target
`timescale 1ns/1ps
module rtc_core #(
    parameter int ONE_SECOND_CYCLES = rtc_pkg::SECOND_CYCLES
) (
    // clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    // supply state
    input wire logic BACKUP,
    // two-wire bus
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // status
    output logic OSC_STOPPED,
    output logic SECOND_PULSE
);
    import rtc_pkg::*;

    state_type state;
    bus_event_type ev;
    logic scl_q, sda_q;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] ptr;
    logic rw, have_ptr, sda_oe, sda_level;
    logic [7:0] seconds, minutes;
    logic [7:0] store [IDX_PLAIN_LO:IDX_PLAIN_HI];
    logic [PRE_WIDTH-1:0] pre;
    logic tick, backup_q;
    logic [3:0] idx;
    logic hit, wr_en;
    logic [7:0] rd_data;
    logic [3:0] next_units;
    logic [2:0] next_tens;
    logic units_wrap, sec_carry;
    logic [3:0] next_min_units;
    logic [2:0] next_min_tens;
    logic min_units_wrap;

    assign SDA_OUT = sda_level;
    assign SDA_OE = sda_oe;
    assign OSC_STOPPED = seconds[STOP_BIT];
    assign SECOND_PULSE = tick;

    // pin sampling and bus condition detection
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_level <= 1'b0;
        end else if (CE) begin
            scl_q <= SCL;
            sda_q <= SDA_IN;
            sda_level <= 1'b0;
        end
    end

    always_comb begin
        ev.start = SCL & scl_q & sda_q & ~SDA_IN;
        ev.stop = SCL & scl_q & ~sda_q & SDA_IN;
        ev.rise = SCL & ~scl_q;
        ev.fall = ~SCL & scl_q;
        ev.sda = SDA_IN;
    end

    // register pointer decode into storage index
    always_comb begin
        idx = 4'h0;
        hit = 1'b0;
        if (ptr <= ADDR_CONFIG_SECOND) begin
            idx = ptr[3:0];
            hit = 1'b1;
        end else if (ptr >= ADDR_SPECIAL_KEY_FIRST && ptr <= ADDR_SPECIAL_FUNCTION) begin
            idx = IDX_SPECIAL_BASE + {2'b00, ptr[1:0]};
            hit = 1'b1;
        end
    end

    always_comb begin
        rd_data = 8'h00;
        if (hit) begin
            case (idx)
                IDX_SECONDS: rd_data = seconds;
                IDX_MINUTES: rd_data = minutes;
                default: rd_data = store[idx];
            endcase
        end
    end

    assign wr_en = CE && !BACKUP && !ev.start && !ev.stop && state == S_WRITE
        && ev.fall && bit_cnt == BYTE_BITS && hit;

    // bus target sequencer
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state <= S_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            ptr <= 8'h00;
            rw <= 1'b0;
            have_ptr <= 1'b0;
            sda_oe <= 1'b0;
        end else if (CE) begin
            if (BACKUP || ev.stop) begin
                state <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (ev.start) begin
                state <= S_ADDR;
                bit_cnt <= 4'h0;
                have_ptr <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    S_ADDR, S_PTR, S_WRITE: begin
                        if (ev.rise) begin
                            shift <= {shift[6:0], ev.sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (ev.fall && bit_cnt == BYTE_BITS) begin
                            bit_cnt <= 4'h0;
                            if (state == S_ADDR && shift[7:1] != DEV_ADDR) begin
                                state <= S_IDLE;
                            end else begin
                                state <= S_ACK;
                                sda_oe <= 1'b1;
                            end
                            if (state == S_ADDR) begin
                                rw <= shift[0];
                            end
                            if (state == S_PTR) begin
                                ptr <= shift;
                                have_ptr <= 1'b1;
                            end
                            if (state == S_WRITE) begin
                                ptr <= ptr + 8'h01;
                            end
                        end
                    end
                    S_ACK: begin
                        if (ev.fall) begin
                            if (rw) begin
                                state <= S_READ;
                                shift <= rd_data;
                                ptr <= ptr + 8'h01;
                                sda_oe <= ~rd_data[7];
                            end else begin
                                state <= have_ptr ? S_WRITE : S_PTR;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    S_READ: begin
                        if (ev.fall) begin
                            if (bit_cnt == BIT_LAST) begin
                                state <= S_MACK;
                                bit_cnt <= 4'h0;
                                sda_oe <= 1'b0;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                                sda_oe <= ~shift[6];
                            end
                        end
                    end
                    S_MACK: begin
                        // master acknowledge asks for the next byte
                        if (ev.rise) begin
                            state <= ev.sda ? S_WAIT : S_ACK;
                        end
                    end
                    S_IDLE, S_WAIT: begin
                        state <= state;
                    end
                    default: begin
                        state <= S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // one-second prescaler
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pre <= '0;
            tick <= 1'b0;
            backup_q <= 1'b0;
        end else if (CE) begin
            backup_q <= BACKUP;
            tick <= 1'b0;
            if (backup_q && !BACKUP) begin
                pre <= '0;
            end else if (pre == PRE_WIDTH'(ONE_SECOND_CYCLES - 1)) begin
                pre <= '0;
                tick <= 1'b1;
            end else begin
                pre <= pre + 1'b1;
            end
        end
    end

    // seconds digits; an invalid digit keeps counting up to its field top
    always_comb begin
        units_wrap = seconds[3:0] == UNITS_MAX || seconds[3:0] == UNITS_TOP;
        next_units = units_wrap ? 4'h0 : seconds[3:0] + 4'h1;
        sec_carry = units_wrap && (seconds[6:4] == TENS_MAX || seconds[6:4] == TENS_TOP);
        next_tens = seconds[6:4];
        if (units_wrap) begin
            next_tens = (seconds[6:4] == TENS_MAX) ? 3'h0 : seconds[6:4] + 3'h1;
        end
        min_units_wrap = minutes[3:0] == UNITS_MAX || minutes[3:0] == UNITS_TOP;
        next_min_units = min_units_wrap ? 4'h0 : minutes[3:0] + 4'h1;
        next_min_tens = minutes[6:4];
        if (min_units_wrap) begin
            next_min_tens = (minutes[6:4] == TENS_MAX) ? 3'h0 : minutes[6:4] + 3'h1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            seconds <= RESET_SECONDS;
        end else if (CE) begin
            if (wr_en && idx == IDX_SECONDS) begin
                seconds <= shift;
            end else if (tick && !seconds[STOP_BIT]) begin
                seconds <= {seconds[STOP_BIT], next_tens, next_units};
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            minutes <= RESET_MINUTES;
        end else if (CE) begin
            if (wr_en && idx == IDX_MINUTES) begin
                minutes <= shift;
            end else if (tick && !seconds[STOP_BIT] && sec_carry) begin
                minutes <= {minutes[FAIL_BIT], next_min_tens, next_min_units};
            end
        end
    end

    // plain stored registers: hours and century onward, and the special group
    for (genvar i = IDX_PLAIN_LO; i <= IDX_PLAIN_HI; i++) begin : g_plain
        always_ff @(posedge CLK_SYS) begin
            if (SRST) begin
                store[i] <= RESET_PLAIN;
            end else if (CE && wr_en && idx == 4'(i)) begin
                store[i] <= shift;
            end
        end
    end

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    a_years_read: assert property (CE && !BACKUP && !ev.start && !ev.stop && state == S_ACK
        && rw && ev.fall && ptr == ADDR_YEARS |=> shift == store[6] && ptr == 8'h07)
        else $error("years register not read at its address");
    a_hours_write: assert property (wr_en && ptr == ADDR_HOURS_CENTURY
        |=> store[2] == $past(shift))
        else $error("hours and century register not written");
    a_charger_write: assert property (wr_en && ptr == ADDR_CHARGER_ENABLE
        |=> store[8] == $past(shift) && ptr == 8'h09)
        else $error("charger enable register not written");
    a_special_write: assert property (wr_en && ptr == ADDR_SPECIAL_FUNCTION
        |=> store[12] == $past(shift))
        else $error("special function register not written");
    a_invalid_units: assert property (CE && tick && !seconds[STOP_BIT] && !wr_en
        && seconds[3:0] == 4'he |=> seconds[3:0] == 4'hf)
        else $error("invalid units digit did not keep counting");
    a_units_roll: assert property (CE && tick && !seconds[STOP_BIT] && !wr_en
        && seconds[3:0] == UNITS_MAX && seconds[6:4] == TENS_TOP |=> seconds[6:0] == 7'h00)
        else $error("invalid tens digit did not roll over");
    a_stop_halts: assert property (seconds[STOP_BIT] && !wr_en
        |=> seconds == $past(seconds))
        else $error("seconds changed while stopped");
    a_tick_bound: assert property (pre < PRE_WIDTH'(ONE_SECOND_CYCLES))
        else $error("prescaler beyond one second");
    a_resume_restart: assert property (CE && backup_q && !BACKUP ##1 CE |-> pre == '0)
        else $error("prescaler not restarted after backup exit");
    a_addr_ack: assert property (CE && !BACKUP && !ev.start && !ev.stop && state == S_ADDR
        && ev.fall && bit_cnt == BYTE_BITS && shift[7:1] == DEV_ADDR
        |=> state == S_ACK && sda_oe ##1 (sda_oe || !CE || !scl_q))
        else $error("own address not acknowledged");
    a_addr_ignore: assert property (CE && !BACKUP && !ev.start && !ev.stop && state == S_ADDR
        && ev.fall && bit_cnt == BYTE_BITS && shift[7:1] != DEV_ADDR |=> state == S_IDLE && !sda_oe)
        else $error("foreign address answered");
    a_read_start: assert property (CE && !BACKUP && !ev.start && !ev.stop && state == S_ACK
        && rw && ev.fall |=> state == S_READ && shift == $past(rd_data) && sda_oe == !shift[7])
        else $error("read byte not taken from pointer");

    c_write_seconds: cover property (wr_en && ptr == ADDR_SECONDS);
    c_read_minutes: cover property (state == S_READ && ptr == 8'h02);
    c_minute_carry: cover property (tick && sec_carry && !seconds[STOP_BIT]);
    c_master_nack: cover property (state == S_WAIT);

endmodule // rtc_core

// ==== tb/rtc_bus_master.sv ====
// two-wire bus master model for the register block
`timescale 1ns/1ps
module rtc_bus_master (
    // clock
    input wire logic clk,
    // bus
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data changes only while the clock is low, sampled mid high phase
    task automatic xbit(input logic b, output logic r);
        sda_low = ~b;
        tick(4);
        scl = 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl = 1'b0;
        tick(4);
    endtask
    // also serves as repeated start when the clock is low
    task automatic start;
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(4);
    endtask
    task automatic stop;
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask
    // msb first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                         output logic ack);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(ack_in, ack);
    endtask
endmodule // rtc_bus_master

// ==== tb/rtc_register_map_seconds_bench.sv ====
// self-checking bench for the register map and seconds counter
`timescale 1ns/1ps
module rtc_register_map_seconds_bench;
    import rtc_pkg::*;
    localparam int SEC = 1000;
    logic clk;
    logic srst;
    logic backup;
    logic ce;
    wire scl;
    wire sda_low;
    wire sda_oe;
    wire sda_out;
    wire osc_stopped;
    wire sec_pulse;
    wire sda;
    int fail_count = 0;
    int cmp_count = 0;
    int pulses = 0;
    // open-drain wire with pull-up; the device pulls low only when it drives a zero
    assign sda = ~((sda_oe & ~sda_out) | sda_low);
    rtc_core #(.ONE_SECOND_CYCLES(SEC)) DUT (.CLK_SYS(clk), .SRST(srst), .CE(ce),
        .BACKUP(backup), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .OSC_STOPPED(osc_stopped), .SECOND_PULSE(sec_pulse));
    rtc_bus_master M (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (sec_pulse === 1'b1) pulses <= pulses + 1;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic nack);
        logic [7:0] r;
        logic ack;
        M.xbyte(a, 1'b1, r, ack);
        check({7'h00, ack}, {7'h00, nack});
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
        M.start();
        put({DEV_ADDR, 1'b0}, 1'b0);
        put(p, 1'b0);
        foreach (d[i]) put(d[i], 1'b0);
        M.stop();
    endtask
    task automatic expect_rd(input logic [7:0] p, input logic [7:0] e[$]);
        logic [7:0] r;
        logic ack;
        M.start();
        put({DEV_ADDR, 1'b0}, 1'b0);
        put(p, 1'b0);
        M.start();
        put({DEV_ADDR, 1'b1}, 1'b0);
        foreach (e[i]) begin
            M.xbyte(8'hff, i == e.size() - 1, r, ack);
            check(r, e[i]);
        end
        M.stop();
    endtask
    task automatic wait_pulses(input int k);
        int p0;
        p0 = pulses;
        for (int i = 0; i < k * SEC + 20 && pulses < p0 + k; i++) @(negedge clk);
        check(8'(pulses - p0), 8'(k));
    endtask
    task automatic t_reset;
        expect_rd(ADDR_SECONDS, {8'h00, 8'h80});
        check({7'h00, osc_stopped}, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_stop;
        wait_pulses(1);
        wr(ADDR_SECONDS, {8'h80});
        check({7'h00, osc_stopped}, 8'h01);
        wait_pulses(2);
        expect_rd(ADDR_SECONDS, {8'h80});
        $display("t_stop done");
    endtask
    task automatic t_map;
        wr(ADDR_MINUTES, {8'h05, 8'hc5, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99});
        expect_rd(ADDR_MINUTES, {8'h05, 8'hc5, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88,
            8'h99});
        wr(ADDR_SPECIAL_KEY_FIRST, {8'ha1, 8'hb2, 8'hc3});
        expect_rd(ADDR_SPECIAL_KEY_FIRST, {8'ha1, 8'hb2, 8'hc3});
        wr(8'h0a, {8'h5a});
        expect_rd(8'h0a, {8'h00});
        expect_rd(ADDR_CONFIG_SECOND, {8'h99});
        $display("t_map done");
    endtask
    task automatic t_count;
        wait_pulses(1);
        wr(ADDR_SECONDS, {8'h79, 8'h05});
        check({7'h00, osc_stopped}, 8'h00);
        wait_pulses(1);
        expect_rd(ADDR_SECONDS, {8'h00, 8'h06});
        wait_pulses(1);
        wr(ADDR_SECONDS, {8'h0e});
        wait_pulses(3);
        expect_rd(ADDR_SECONDS, {8'h11, 8'h06});
        $display("t_count done");
    endtask
    task automatic t_addr;
        for (int i = 0; i < 2; i++) begin
            M.start();
            put(i ? 8'h00 : 8'hd2, 1'b1);
            M.stop();
        end
        $display("t_addr done");
    endtask
    task automatic t_backup;
        int n;
        backup = 1'b1;
        M.start();
        put({DEV_ADDR, 1'b0}, 1'b1);
        M.stop();
        backup = 1'b0;
        @(negedge clk);
        // the restart puts the first pulse one full second after the exit
        for (n = 1; n < SEC + 5 && sec_pulse !== 1'b1; n++) @(negedge clk);
        check(8'(n >= SEC - 2 && n <= SEC + 2), 8'h01);
        $display("t_backup done");
    endtask
    task automatic t_freeze;
        int p0;
        // let any pending pulse clear so it is not frozen high
        repeat (2) @(negedge clk);
        p0 = pulses;
        ce = 1'b0;
        M.start();
        put({DEV_ADDR, 1'b0}, 1'b1);
        M.stop();
        repeat (2 * SEC) @(negedge clk);
        check(8'(pulses - p0), 8'h00);
        ce = 1'b1;
        wait_pulses(1);
        $display("t_freeze done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        backup = 1'b0;
        ce = 1'b1;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_stop();
        t_map();
        t_count();
        t_addr();
        t_backup();
        t_freeze();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule // rtc_register_map_seconds_bench
